// [core/ssp_top.sv]
`include "ssp_cfg.svh"

module ssp_top
  import ssp_pkg::*;
#(
  parameter int         TIMEOUT_CYC = `SSP_TIMEOUT_CYC, // bus time-out in core clocks
  parameter logic [7:0] ID_VALUE    = `SSP_ID_DEFAULT   // arbitrary identification value
) (
  input  wire logic       core_clk,  // core clock, 100 MHz
  input  wire logic       reset,     // sync reset, active high
  input  wire logic       sclIn,     // serial clock pin level
  input  wire logic       sdaIn,     // serial data pin level
  output logic            sdaOut,    // serial data drive value, always 0
  output logic            sdaOutEnN, // low while pulling data low
  input  wire logic       measWe,    // measurement path writes a result
  input  wire logic [5:0] measAddr,  // result register index
  input  wire logic [7:0] measData,  // result value
  input  wire logic       convDone,  // conversion cycle finished, pulse
  output logic            convRun,   // conversions allowed, level
  output logic            convStart, // one-shot start, pulse
  output logic            convAbort, // abort conversion, pulse
  output logic            hsMode     // high-speed filters selected
);
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

  ssp_mem_if  memBus ();
  ssp_state_t state_r;
  logic [1:0] lineFilt;
  logic [1:0] pinIn;
  logic [1:0] filtLen;
  logic       sclPrev_r, sdaPrev_r;
  logic       sclRise, sclFall, startDet, stopDet;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r, txShift_r, ptr_r, rdByte;
  logic       isAddr_r, readDir_r, genCall_r, ptrDone_r;
  logic       sdaOutEnN_r, sdaOut_r, hsMode_r, softRst_r;
  logic       fifoInValid_r, fifoInReady, fifoOutValid, fifoOutReady, drainFire;
  logic [15:0] fifoInData_r, fifoOutData;
  logic [TO_W-1:0] toCnt_r;
  logic       timeoutHit;
  logic       initBusy_r;
  logic [5:0] initCnt_r;
  logic [7:0] cfgShadow_r, caShadow_r;
  logic       oneShot_r, convRun_r, convStart_r, convAbort_r;
  logic [7:0] drainPtr, drainData, drainMasked;
  logic [5:0] drainIdx;
  logic       drainWritable;

  // ============================================================
  // helpers
  function automatic logic [7:0] porValue(input logic [5:0] idx);
    case (idx)
      `SSP_IDX_CONVRATE: porValue = `SSP_POR_CONVRATE;
      `SSP_IDX_LHIGH:    porValue = `SSP_POR_LIMIT_HI;
      `SSP_IDX_RHIGH:    porValue = `SSP_POR_LIMIT_HI;
      `SSP_IDX_RTHERM:   porValue = `SSP_POR_RTHERM;
      `SSP_IDX_LTHERM:   porValue = `SSP_POR_LTHERM;
      `SSP_IDX_HYST:     porValue = `SSP_POR_HYST;
      `SSP_IDX_CONSAL:   porValue = `SSP_POR_CONSAL;
      default:           porValue = `SSP_POR_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] writeMask(input logic [5:0] idx);
    case (idx)
      `SSP_IDX_CFG:      writeMask = `SSP_CFG_WMASK;
      `SSP_IDX_CONVRATE: writeMask = `SSP_CR_WMASK;
      `SSP_IDX_CONSAL:   writeMask = `SSP_CA_WMASK;
      `SSP_IDX_DFILT:    writeMask = `SSP_DF_WMASK;
      default:           writeMask = 8'hFF;
    endcase
  endfunction

  // ============================================================
  // pin synchronisers and spike filters
  assign pinIn = {sclIn, sdaIn};
  assign filtLen = hsMode_r ? 2'(`SSP_HS_FILT_CYC) : 2'(`SSP_FS_FILT_CYC);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic [2:0] sync_r;
      logic [1:0] cnt_r;
      logic       filt_r;
      always_ff @(posedge core_clk) begin
        if (reset) begin
          sync_r <= 3'h7;
          cnt_r  <= 2'h0;
          filt_r <= 1'b1;
        end else begin
          sync_r <= {sync_r[1:0], pinIn[g]};
          if ((sync_r[1] == sync_r[2]) && (sync_r[2] != filt_r)) begin
            if (cnt_r >= filtLen - 2'h1) begin
              filt_r <= sync_r[2];
              cnt_r  <= 2'h0;
            end else begin
              cnt_r <= cnt_r + 2'h1;
            end
          end else begin
            cnt_r <= 2'h0;
          end
        end
      end
      assign lineFilt[g] = filt_r;
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= lineFilt[1];
      sdaPrev_r <= lineFilt[0];
    end
  end

  assign sclRise  = lineFilt[1] && !sclPrev_r;
  assign sclFall  = !lineFilt[1] && sclPrev_r;
  assign startDet = sclPrev_r && lineFilt[1] && sdaPrev_r && !lineFilt[0];
  assign stopDet  = sclPrev_r && lineFilt[1] && !sdaPrev_r && lineFilt[0];

  // ============================================================
  // read data selection
  assign memBus.raddr = ptr_r[5:0];
  always_comb begin
    if (ptr_r == `SSP_PTR_ID) begin
      rdByte = ID_VALUE;
    end else if (ptr_r[7:6] != 2'h0) begin
      rdByte = 8'h00;
    end else begin
      rdByte = memBus.rdata;
    end
  end

  // ============================================================
  // bus time-out
  // enable from bit 7
  always_ff @(posedge core_clk) begin
    if (reset || state_r == ST_IDLE || !caShadow_r[`SSP_CA_TO_BIT] ||
        (lineFilt[1] && lineFilt[0])) begin
      toCnt_r <= '0;
    end else if (!timeoutHit) begin
      toCnt_r <= toCnt_r + 1'b1;
    end
  end
  assign timeoutHit = (toCnt_r == TO_W'(TIMEOUT_CYC - 1));

  // ============================================================
  // serial protocol engine; only the data line is ever driven
  // data line only
  always_ff @(posedge core_clk) begin
    sdaOut_r <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r       <= ST_IDLE;
      bitCnt_r      <= 4'h0;
      shift_r       <= 8'h00;
      txShift_r     <= 8'h00;
      isAddr_r      <= 1'b0;
      readDir_r     <= 1'b0;
      genCall_r     <= 1'b0;
      ptrDone_r     <= 1'b0;
      ptr_r         <= 8'h00;
      sdaOutEnN_r   <= 1'b1;
      hsMode_r      <= 1'b0;
      softRst_r     <= 1'b0;
      fifoInValid_r <= 1'b0;
      fifoInData_r  <= 16'h0000;
    end else begin
      softRst_r     <= 1'b0;
      fifoInValid_r <= 1'b0;
      if (stopDet) begin
        state_r     <= ST_IDLE;
        sdaOutEnN_r <= 1'b1;
        hsMode_r    <= 1'b0;
      end else if (startDet) begin
        state_r     <= ST_SHIFT_IN;
        bitCnt_r    <= 4'h0;
        isAddr_r    <= 1'b1;
        sdaOutEnN_r <= 1'b1;
      end else if (timeoutHit) begin
        state_r     <= ST_IDLE;
        sdaOutEnN_r <= 1'b1;
      end else begin
        case (state_r)
          ST_SHIFT_IN: begin
            if (sclRise) begin
              shift_r  <= {shift_r[6:0], lineFilt[0]};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= 4'h0;
              isAddr_r <= 1'b0;
              if (isAddr_r) begin
                if (shift_r[7:3] == `SSP_HS_CODE) begin
                  hsMode_r <= 1'b1;
                  state_r  <= ST_WAIT;
                end else if (shift_r[7:1] == `SSP_OWN_ADDR) begin
                  sdaOutEnN_r <= 1'b0;
                  readDir_r   <= shift_r[0];
                  genCall_r   <= 1'b0;
                  ptrDone_r   <= 1'b0;
                  state_r     <= ST_ACK;
                end else if (shift_r == `SSP_GC_ADDR) begin
                  sdaOutEnN_r <= 1'b0;
                  readDir_r   <= 1'b0;
                  genCall_r   <= 1'b1;
                  ptrDone_r   <= 1'b0;
                  state_r     <= ST_ACK;
                end else begin
                  state_r <= ST_WAIT;
                end
              end else if (genCall_r) begin
                sdaOutEnN_r <= 1'b0;
                ptrDone_r   <= 1'b1;
                state_r     <= ST_ACK;
                if (shift_r == `SSP_GC_RESET) begin
                  softRst_r <= 1'b1;
                  ptr_r     <= 8'h00;
                end
              end else if (!ptrDone_r) begin
                ptr_r       <= shift_r;
                ptrDone_r   <= 1'b1;
                sdaOutEnN_r <= 1'b0;
                state_r     <= ST_ACK;
              end else if (fifoInReady) begin
                fifoInValid_r <= 1'b1;
                fifoInData_r  <= {ptr_r, shift_r};
                sdaOutEnN_r   <= 1'b0;
                state_r       <= ST_ACK;
              end else begin
                // full buffer: refuse the byte
                state_r <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              bitCnt_r <= 4'h0;
              if (readDir_r) begin
                txShift_r   <= rdByte;
                sdaOutEnN_r <= rdByte[7];
                state_r     <= ST_SHIFT_OUT;
              end else begin
                sdaOutEnN_r <= 1'b1;
                state_r     <= (genCall_r && ptrDone_r) ? ST_WAIT : ST_SHIFT_IN;
              end
            end
          end
          ST_SHIFT_OUT: begin
            if (sclRise) begin
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                sdaOutEnN_r <= 1'b1;
                state_r     <= ST_MASTER_ACK;
              end else begin
                txShift_r   <= {txShift_r[6:0], 1'b0};
                sdaOutEnN_r <= txShift_r[6];
              end
            end
          end
          ST_MASTER_ACK: begin
            if (sclRise && lineFilt[0]) begin
              state_r <= ST_WAIT;
            end else if (sclFall) begin
              bitCnt_r    <= 4'h0;
              txShift_r   <= rdByte;
              sdaOutEnN_r <= rdByte[7];
              state_r     <= ST_SHIFT_OUT;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ============================================================
  // write buffer and register update
  ssp_fifo #(
    .WIDTH (`SSP_FIFO_WIDTH),
    .DEPTH (`SSP_FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .reset    (reset),
    .flush    (softRst_r),
    .inValid  (fifoInValid_r),
    .inReady  (fifoInReady),
    .inData   (fifoInData_r),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // result writes from the measurement side have priority over bus writes
  assign fifoOutReady  = !initBusy_r && !measWe;
  assign drainFire     = fifoOutValid && fifoOutReady;
  assign drainPtr      = fifoOutData[15:8];
  assign drainData     = fifoOutData[7:0];
  assign drainIdx      = ((drainPtr >= `SSP_WR_ALIAS_LO) && (drainPtr <= `SSP_WR_ALIAS_HI)) ?
                         6'(drainPtr - `SSP_WR_ALIAS_OFS) : drainPtr[5:0];
  assign drainWritable = ((drainPtr >= `SSP_WR_ALIAS_LO) && (drainPtr <= `SSP_WR_ALIAS_HI)) ||
                         ((drainPtr >= `SSP_WR_A_LO) && (drainPtr <= `SSP_WR_A_HI)) ||
                         ((drainPtr >= `SSP_WR_B_LO) && (drainPtr <= `SSP_WR_B_HI));
  assign drainMasked   = (drainData & writeMask(drainIdx)) |
                         ((drainIdx == `SSP_IDX_CONSAL) ? `SSP_CA_FIXED : 8'h00);

  always_comb begin
    memBus.we    = 1'b0;
    memBus.waddr = 6'h00;
    memBus.wdata = 8'h00;
    if (initBusy_r) begin
      memBus.we    = 1'b1;
      memBus.waddr = initCnt_r;
      memBus.wdata = porValue(initCnt_r);
    end else if (measWe) begin
      memBus.we    = 1'b1;
      memBus.waddr = measAddr;
      memBus.wdata = measData;
    end else if (drainFire && drainWritable) begin
      memBus.we    = 1'b1;
      memBus.waddr = drainIdx;
      memBus.wdata = drainMasked;
    end
  end

  ssp_regmem u_regmem (
    .core_clk (core_clk),
    .memBus   (memBus.store)
  );

  always_ff @(posedge core_clk) begin
    if (reset || softRst_r) begin
      initBusy_r  <= 1'b1;
      initCnt_r   <= 6'h00;
      cfgShadow_r <= `SSP_POR_CFG;
      caShadow_r  <= `SSP_POR_CONSAL;
      oneShot_r   <= 1'b0;
      convStart_r <= 1'b0;
      convRun_r   <= 1'b0;
      convAbort_r <= !reset;
    end else begin
      convStart_r <= 1'b0;
      convAbort_r <= 1'b0;
      if (initBusy_r) begin
        initCnt_r <= initCnt_r + 6'h01;
        if (initCnt_r == 6'h3F) begin
          initBusy_r <= 1'b0;
        end
      end
      if (convDone) begin
        oneShot_r <= 1'b0;
      end
      if (drainFire) begin
        if (drainPtr == `SSP_PTR_ONESHOT) begin
          if (cfgShadow_r[`SSP_CFG_SD_BIT]) begin
            oneShot_r   <= 1'b1;
            convStart_r <= 1'b1;
          end
        end else if (drainWritable && drainIdx == `SSP_IDX_CFG) begin
          cfgShadow_r <= drainMasked;
        end else if (drainWritable && drainIdx == `SSP_IDX_CONSAL) begin
          caShadow_r <= drainMasked;
        end
      end
      convRun_r <= !cfgShadow_r[`SSP_CFG_SD_BIT] || oneShot_r;
    end
  end

  assign sdaOut    = sdaOut_r;
  assign sdaOutEnN = sdaOutEnN_r;
  assign convRun   = convRun_r;
  assign convStart = convStart_r;
  assign convAbort = convAbort_r;
  assign hsMode    = hsMode_r;
endmodule // ssp_top

// [core/ssp_cfg.svh]
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ============================================================
// bus addressing
`define SSP_OWN_ADDR      7'h4C
`define SSP_GC_ADDR       8'h00
`define SSP_GC_RESET      8'h06
`define SSP_HS_CODE       5'h01
// ============================================================
// pointer locations
`define SSP_PTR_ONESHOT   8'h0F
`define SSP_PTR_ID        8'hFE
`define SSP_WR_ALIAS_LO   8'h09
`define SSP_WR_ALIAS_HI   8'h0E
`define SSP_WR_ALIAS_OFS  8'h06
`define SSP_WR_A_LO       8'h11
`define SSP_WR_A_HI       8'h14
`define SSP_WR_B_LO       8'h19
`define SSP_WR_B_HI       8'h24
`define SSP_IDX_CFG       6'h03
`define SSP_IDX_CONVRATE  6'h04
`define SSP_IDX_LHIGH     6'h05
`define SSP_IDX_RHIGH     6'h07
`define SSP_IDX_RTHERM    6'h19
`define SSP_IDX_LTHERM    6'h20
`define SSP_IDX_HYST      6'h21
`define SSP_IDX_CONSAL    6'h22
`define SSP_IDX_DFILT     6'h24
// ============================================================
// fields and masks
`define SSP_CFG_SD_BIT    6
`define SSP_CA_TO_BIT     7
`define SSP_CFG_WMASK     8'hE4
`define SSP_CR_WMASK      8'h0F
`define SSP_CA_WMASK      8'h8E
`define SSP_CA_FIXED      8'h01
`define SSP_DF_WMASK      8'h03
// ============================================================
// power-on values
`define SSP_POR_ZERO      8'h00
`define SSP_POR_CFG       8'h00
`define SSP_POR_CONVRATE  8'h08
`define SSP_POR_LIMIT_HI  8'h55
`define SSP_POR_RTHERM    8'h6C
`define SSP_POR_LTHERM    8'h55
`define SSP_POR_HYST      8'h0A
`define SSP_POR_CONSAL    8'h01
// arbitrary identification value
`define SSP_ID_DEFAULT    8'h3A
// ============================================================
// sizes and timing
`define SSP_MEM_DEPTH     64
`define SSP_FIFO_DEPTH    32
`define SSP_FIFO_WIDTH    16
`define SSP_CLK_MHZ       100
`define SSP_TIMEOUT_MS    25
`define SSP_TIMEOUT_CYC   (`SSP_TIMEOUT_MS * 1000 * `SSP_CLK_MHZ)
`define SSP_FS_SPIKE_NS   30
`define SSP_HS_SPIKE_NS   10
`define SSP_FS_FILT_CYC   ((`SSP_FS_SPIKE_NS * `SSP_CLK_MHZ) / 1000)
`define SSP_HS_FILT_CYC   ((`SSP_HS_SPIKE_NS * `SSP_CLK_MHZ) / 1000)

`endif

// [core/ssp_pkg.sv]
package ssp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT_IN,
    ST_ACK,
    ST_SHIFT_OUT,
    ST_MASTER_ACK,
    ST_WAIT
  } ssp_state_t;

  typedef logic [7:0]  ssp_byte_t;
  typedef logic [5:0]  ssp_idx_t;
  typedef logic [15:0] ssp_word_t;
endpackage

// [core/ssp_mem_if.sv]
interface ssp_mem_if;
  logic             we;
  logic [5:0]       waddr;
  logic [7:0]       wdata;
  logic [5:0]       raddr;
  logic [7:0]       rdata;

  modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [core/ssp_regmem.sv]
`include "ssp_cfg.svh"

module ssp_regmem
  import ssp_pkg::*;
(
  input  wire logic core_clk, // core clock
  ssp_mem_if.store  memBus    // register storage port
);
  logic [7:0] store_r [`SSP_MEM_DEPTH];
  logic [7:0] rdata_r;

  // no reset here: the controller sweeps power-on values in
  always_ff @(posedge core_clk) begin
    if (memBus.we) begin
      store_r[memBus.waddr] <= memBus.wdata;
    end
    rdata_r <= store_r[memBus.raddr];
  end

  assign memBus.rdata = rdata_r;
endmodule // ssp_regmem

// [core/ssp_fifo.sv]
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk, // core clock
  input  wire logic             reset,    // sync reset, active high
  input  wire logic             flush,    // drop all entries
  input  wire logic             inValid,  // write request
  output logic                  inReady,  // room for one more
  input  wire logic [WIDTH-1:0] inData,   // write data
  output logic                  outValid, // entry available
  input  wire logic             outReady, // consumer takes entry
  output logic [WIDTH-1:0]      outData   // head entry
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  logic             push;
  logic             pop;

  assign inReady  = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
  assign outValid = (wrPtr_r != rdPtr_r);
  assign outData  = mem_r[rdPtr_r[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wrPtr_r[AW-1:0]] <= inData;
    end
  end
endmodule // ssp_fifo

// [verif/ssp_top_assertions.sv]
module ssp_top_assertions #(
  parameter int TIMEOUT_CYC = 200 // bus time-out cycles
) (
  input wire logic core_clk,  // core clock
  input wire logic reset,     // sync reset
  input wire logic sclIn,     // clock pin
  input wire logic sdaOut,    // drive value
  input wire logic sdaOutEnN, // pull enable
  input wire logic convRun,   // conversions on
  input wire logic convStart, // one-shot pulse
  input wire logic convAbort, // abort pulse
  input wire logic hsMode     // fast filters on
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // port relations
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // clock held low long enough that no stop can be pending
  sequence sclLowLong;
    (!sclIn) [*8];
  endsequence
  drive_zero_a: assert property (sdaOut == 1'b0)
    else $error("data drive value not zero");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("one-shot start longer than one cycle");
  start_run_a: assert property (convStart |=> convRun)
    else $error("no conversion after one-shot start");
  abort_pulse_a: assert property (convAbort |=> !convAbort)
    else $error("abort longer than one cycle");
  hs_hold_a: assert property (sclLowLong ##0 hsMode |=> hsMode)
    else $error("high-speed left with clock low");
  ack_edge_a: assert property ($changed(sdaOutEnN) |-> !sclIn)
    else $error("data drive changed with clock high");
  hs_nack_a: assert property ($rose(hsMode) |-> sdaOutEnN [*8])
    else $error("high-speed code acknowledged");
  reset_idle_a: assert property ($fell(reset) |-> sdaOutEnN && !hsMode && !convRun)
    else $error("outputs not idle after reset");
endmodule // ssp_top_assertions

// [verif/ssp_master_model.sv]
module ssp_master_model (
  output logic      sclLine, // serial clock
  output logic      sdaRel,  // 1 releases data
  input  wire logic sdaBus   // resolved data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // bit and frame timing
  // clock made here only
  initial begin
    sclLine = 1'b1;
    sdaRel  = 1'b1;
  end
  // data bits move only while clock low
  // even-ns steps keep pin changes off the rising core clock edge
  task automatic bitx(input logic b, output logic s);
    #62 sdaRel = b;
    #62 sclLine = 1'b1;
    #62 s = sdaBus;
    sclLine = 1'b0;
  endtask
  task automatic start();
    #62 sdaRel = 1'b1;
    #62 sclLine = 1'b1;
    #62 sdaRel = 1'b0;
    #62 sclLine = 1'b0;
  endtask
  task automatic stop();
    #62 sdaRel = 1'b0;
    #62 sclLine = 1'b1;
    #62 sdaRel = 1'b1;
    #62;
  endtask
  // top bit first, ack read back
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(last, s);
  endtask
endmodule // ssp_master_model

// [verif/sensor_serial_slave_port_test.sv]
`include "ssp_cfg.svh"

module sensor_serial_slave_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk    = 1'b0;
  logic       reset       = 1'b1;
  logic       measWe      = 1'b0;
  logic [5:0] measAddr    = 6'h00;
  logic [7:0] measData    = 8'h5A;
  logic       convDone    = 1'b0;
  logic       startSeen   = 1'b0;
  logic       abortSeen   = 1'b0;
  logic       scl, sdaRel, sdaOut, sdaOutEnN, convRun, convStart, convAbort, hsMode;
  int         failures    = 0;
  int         totalChecks = 0;
  // pull-up: either party pulling low wins
  wire        sdaBus      = sdaRel & sdaOutEnN;
  // ==========
  // clock, design and far side
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (convStart) startSeen <= 1'b1;
    if (convAbort) abortSeen <= 1'b1;
  end
  ssp_top #(.TIMEOUT_CYC(200)) dut (
    .core_clk(core_clk), .reset(reset), .sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut),
    .sdaOutEnN(sdaOutEnN), .measWe(measWe), .measAddr(measAddr), .measData(measData),
    .convDone(convDone), .convRun(convRun), .convStart(convStart),
    .convAbort(convAbort), .hsMode(hsMode));
  ssp_master_model m (.sclLine(scl), .sdaRel(sdaRel), .sdaBus(sdaBus));
  // ==========
  // access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrN(input logic [7:0] p, input logic [7:0] d, input int n, input logic ak);
    logic a;
    m.start();
    m.wbyte(8'h98, a);
    check(a, 1'b1);
    m.wbyte(p, a);
    for (int i = 0; i < n; i++) m.wbyte(d, a);
    check(a, ak);
    m.stop();
  endtask
  task automatic rd(input logic setp, input logic [7:0] p, input logic [7:0] exp);
    logic       a;
    logic [7:0] b;
    m.start();
    if (setp) begin
      m.wbyte(8'h98, a);
      m.wbyte(p, a);
      m.start();
    end
    m.wbyte(8'h99, a);
    check(a, 1'b1);
    m.rbyte(1'b0, b);
    check(b, exp);
    m.rbyte(1'b1, b);
    check(b, exp);
    m.stop();
  endtask
  task automatic summarize();
    if (failures == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // scenarios
  initial begin
    logic a;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    repeat (80) @(negedge core_clk);
    @(negedge core_clk) measWe = 1'b1;
    @(negedge core_clk) measWe = 1'b0;
    rd(1'b0, 8'h00, 8'h5A);
    check(convRun, 1'b1);
    m.start();
    m.wbyte(8'h9A, a);
    check(a, 1'b0);
    m.stop();
    wrN(8'h09, 8'h40, 1, 1'b1);
    #200 check(convRun, 1'b0);
    rd(1'b1, 8'h03, 8'h40);
    rd(1'b1, 8'hFE, `SSP_ID_DEFAULT);
    wrN(8'h0F, 8'hA5, 1, 1'b1);
    check(startSeen, 1'b1);
    check(convRun, 1'b1);
    @(negedge core_clk) convDone = 1'b1;
    @(negedge core_clk) convDone = 1'b0;
    #50 check(convRun, 1'b0);
    rd(1'b1, 8'h0F, 8'h00);
    m.start();
    m.wbyte(8'h08, a);
    check(a, 1'b0);
    check(hsMode, 1'b1);
    m.start();
    m.wbyte(8'h98, a);
    check(a, 1'b1);
    check(hsMode, 1'b1);
    m.stop();
    #200 check(hsMode, 1'b0);
    m.start();
    m.wbyte(8'h00, a);
    check(a, 1'b1);
    m.wbyte(8'h06, a);
    check(a, 1'b1);
    m.stop();
    check(abortSeen, 1'b1);
    rd(1'b1, 8'h03, 8'h00);
    // storage writes stall the queue until it refuses
    @(negedge core_clk) measWe = 1'b1;
    wrN(8'h11, 8'h3C, 40, 1'b0);
    @(negedge core_clk) measWe = 1'b0;
    rd(1'b1, 8'h11, 8'h3C);
    wrN(8'h22, 8'h80, 1, 1'b1);
    rd(1'b1, 8'h22, 8'h81);
    wrN(8'h06, 8'h00, 0, 1'b1);
    m.start();
    m.wbyte(8'h99, a);
    #500 check(sdaOutEnN, 1'b0);
    #2500 check(sdaOutEnN, 1'b1);
    m.stop();
    summarize();
  end
  initial begin
    #900000;
    failures++;
    summarize();
  end
endmodule // sensor_serial_slave_port_test

bind ssp_top ssp_top_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
  .core_clk(core_clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOutEnN(sdaOutEnN), .convRun(convRun), .convStart(convStart),
  .convAbort(convAbort), .hsMode(hsMode));
